// File: rtl/seg_attr_pkg.sv
`default_nettype none
package seg_attr_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] ATTR_IDX_0 = 8'h59;
    localparam logic [7:0] ATTR_IDX_6 = 8'h5F;
    localparam int NUM_REGS = 7;
    localparam int NUM_SEGS = 14;
    localparam logic [7:0] ATTR_RESET = 8'h00;
    // nibble field positions
    localparam int BIT_RD = 0;
    localparam int BIT_WR = 1;
    localparam int BIT_CE = 2;
    localparam int NIB_W = 4;
    // hole register (own choice), index 0x60 -> byte 0x180
    localparam logic [7:0] HOLE_IDX = 8'h60;
    localparam logic [31:0] HOLE_RESET = 32'h0000_0000;
    // address map, 20-bit legacy addresses
    localparam logic [19:0] EXP_BASE = 20'hC0000;
    localparam logic [19:0] SYS_BIOS_BASE = 20'hF0000;
    localparam int SEG16_SHIFT = 14;
    localparam int AP_W = 12;
endpackage
`default_nettype wire

// File: rtl/segment_attribute_map.sv
// Overview of operation
// RL1: seven attribute registers cover thirteen segments
// RL2: each register holds two 4-bit nibble fields
// RL3: nibble bits: read, write, cache, reserved
// RL4: read enable steers cpu reads to memory
// RL5: write enable steers cpu writes to memory
// RL6: cache enable reports segment L1 cacheable
// RL7: software never sets cache without read
// RL8: cache with write off: code reads only
// RL9: read-only writes ignored, passed to pci
// RL10: read-only segments never allocated in L2
// RL11: write-only reads go to pci
// RL12: disabled segment forwards everything to pci
// RL13: read/write segment is ordinary memory
// RL14: writable segment claims pci master writes
// RL15: readable segment claims pci master reads
// RL16: no devsel for disallowed pci accesses
// RL17: never claim pci accesses inside holes
// RL18: C0000-DFFFF eight 16K segments, regs 1-4
// RL19: E0000-EFFFF four 16K segments, regs 5-6
// RL20: F0000-FFFFF one segment, reg0 upper nibble
// RL21: software keeps cache bit while L2 enabled
// RL22: decode address; others unaffected
`default_nettype none
module segment_attribute_map (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu access decode
    input wire logic cpu_valid_in,
    input wire logic [31:0] cpu_addr_in,
    input wire logic cpu_write_in,
    input wire logic cpu_code_in,
    output logic cpu_to_mem_out,
    output logic cpu_to_pci_out,
    output logic l1_cacheable_out,
    output logic l2_alloc_out,
    // pci master decode
    input wire logic pci_valid_in,
    input wire logic [31:0] pci_addr_in,
    input wire logic pci_write_in,
    output logic pci_claim_out
);
    typedef struct packed {
        logic [seg_attr_pkg::NUM_REGS-1:0][7:0] attr;
        logic [31:0] hole;
        logic [31:0] rdata;
        logic mem, pci, l1, l2, claim;
    } state_t;
    state_t st_r, st_nxt;

    logic [9:0] widx;
    logic unmapped;
    logic [3:0] cpu_nib, pci_nib;
    logic cpu_hit, pci_hit, pci_in_hole;
    logic [seg_attr_pkg::NUM_SEGS-1:0][3:0] seg_nib;

    // segment k -> nibble; seg 0 is F0000, 1..12 are C0000..EFFFF
    genvar g;
    generate
        for (g = 0; g < seg_attr_pkg::NUM_SEGS - 1; g++) begin : gen_seg
            assign seg_nib[g + 1] = st_r.attr[(g + 2) / 2][
                ((g % 2) * seg_attr_pkg::NIB_W) +: seg_attr_pkg::NIB_W]; // RL18 RL19
        end
    endgenerate
    assign seg_nib[0] = st_r.attr[0][7:4]; // RL20

    function automatic logic [4:0] lookup(input logic [31:0] a,
            input logic [seg_attr_pkg::NUM_SEGS-1:0][3:0] t);
        logic [3:0] idx;
        idx = 4'h0;
        lookup = 5'h00;
        if (a[31:20] == 12'h000 && a[19:0] >= seg_attr_pkg::EXP_BASE) begin // RL22
            if (a[19:0] >= seg_attr_pkg::SYS_BIOS_BASE) begin
                lookup = {1'b1, t[0]};
            end else begin
                idx = 4'(((a[19:0] - seg_attr_pkg::EXP_BASE)
                    >> seg_attr_pkg::SEG16_SHIFT) + 20'd1);
                lookup = {1'b1, t[idx]};
            end
        end
    endfunction

    always_comb begin
        {cpu_hit, cpu_nib} = lookup(cpu_addr_in, seg_nib);
        {pci_hit, pci_nib} = lookup(pci_addr_in, seg_nib);
        pci_in_hole = st_r.hole[0] && pci_addr_in[31:20] == 12'h000
            && pci_addr_in[19:0] >= st_r.hole[31:12]
            && pci_addr_in[19:0] < {st_r.hole[11:4], 12'h000};
    end

    assign widx = paddr[11:2];
    assign unmapped = !((widx >= 10'(seg_attr_pkg::ATTR_IDX_0)
        && widx <= 10'(seg_attr_pkg::ATTR_IDX_6))
        || widx == 10'(seg_attr_pkg::HOLE_IDX));

    always_comb begin
        st_nxt = st_r;
        if (psel && !penable) begin
            st_nxt.rdata = 32'h0000_0000;
            if (widx == 10'(seg_attr_pkg::HOLE_IDX)) begin
                st_nxt.rdata = st_r.hole;
            end else if (!unmapped) begin
                st_nxt.rdata = {24'h000000,
                    st_r.attr[3'(widx - 10'(seg_attr_pkg::ATTR_IDX_0))]};
            end
        end
        if (psel && penable && pwrite && !unmapped) begin
            if (widx == 10'(seg_attr_pkg::HOLE_IDX)) begin
                st_nxt.hole = pwdata;
            end else begin
                st_nxt.attr[3'(widx - 10'(seg_attr_pkg::ATTR_IDX_0))] =
                    pwdata[7:0]; // RL1 RL2
            end
        end
        // cpu steering; reserved bit 3 ignored
        st_nxt.mem = 1'b0;
        st_nxt.pci = 1'b0;
        st_nxt.l1 = 1'b0;
        st_nxt.l2 = 1'b0;
        if (cpu_valid_in) begin
            if (!cpu_hit) begin
                st_nxt.mem = 1'b1;
                st_nxt.l1 = 1'b1;
                st_nxt.l2 = 1'b1;
            end else begin
                st_nxt.mem = cpu_write_in ? cpu_nib[seg_attr_pkg::BIT_WR] // RL3
                    : cpu_nib[seg_attr_pkg::BIT_RD]; // RL4 RL5 RL11 RL12
                st_nxt.pci = !st_nxt.mem; // RL9
                st_nxt.l1 = cpu_nib[seg_attr_pkg::BIT_CE]
                    && (cpu_nib[seg_attr_pkg::BIT_WR]
                    || (cpu_code_in && !cpu_write_in)); // RL6 RL8
                st_nxt.l2 = st_nxt.mem && cpu_nib[seg_attr_pkg::BIT_RD]
                    && cpu_nib[seg_attr_pkg::BIT_WR]; // RL10 RL13
            end
        end
        st_nxt.claim = pci_valid_in && pci_hit && !pci_in_hole
            && (pci_write_in ? pci_nib[seg_attr_pkg::BIT_WR]
            : pci_nib[seg_attr_pkg::BIT_RD]); // RL14 RL15 RL16 RL17
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && unmapped;
    assign cpu_to_mem_out = st_r.mem;
    assign cpu_to_pci_out = st_r.pci;
    assign l1_cacheable_out = st_r.l1;
    assign l2_alloc_out = st_r.l2;
    assign pci_claim_out = st_r.claim;

    chk_ro_write_pci: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        cpu_valid_in && cpu_hit && cpu_write_in && !cpu_nib[1]
        |=> cpu_to_pci_out && !cpu_to_mem_out && !l2_alloc_out)
        else $error("read-only write not sent to pci"); // RL9
    chk_read_steer: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        cpu_valid_in && cpu_hit && !cpu_write_in
        |=> cpu_to_mem_out == $past(cpu_nib[0]))
        else $error("cpu read steering wrong"); // RL4
    chk_ro_no_l2: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        cpu_valid_in && cpu_hit && !cpu_nib[1] |=> !l2_alloc_out)
        else $error("read-only segment allocated in l2"); // RL10
    chk_l1_code_only: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        cpu_valid_in && cpu_hit && !cpu_nib[1] && !cpu_code_in
        |=> !l1_cacheable_out)
        else $error("data read cached in write-protected segment"); // RL8
    chk_pci_hole: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        pci_valid_in && pci_in_hole |=> !pci_claim_out)
        else $error("pci access in hole claimed"); // RL17
    chk_pci_claim: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        pci_valid_in && pci_hit && !pci_in_hole && pci_write_in
        |=> pci_claim_out == $past(pci_nib[1]))
        else $error("pci write claim wrong"); // RL14
    chk_pci_noclaim: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !pci_valid_in |=> !pci_claim_out)
        else $error("claim without request"); // RL16
    chk_rw_memory: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        cpu_valid_in && cpu_hit && cpu_nib[0] && cpu_nib[1]
        |=> cpu_to_mem_out && l2_alloc_out)
        else $error("read/write segment not ordinary memory"); // RL13
endmodule
`default_nettype wire

// File: sim/host_query_src.sv
`default_nettype none
module host_query_src (
    // clock
    input wire logic clk_in,
    // query lines
    output logic valid_out,
    output logic [31:0] addr_out,
    output logic write_out,
    output logic code_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {valid_out, addr_out, write_out, code_out} = '0;
    // one query per call; idle address inverted
    task automatic ask(input logic [31:0] a, input logic w, input logic c);
        @(posedge clk_in);
        valid_out <= 1'b1;
        addr_out <= a;
        write_out <= w;
        code_out <= c;
        @(posedge clk_in);
        valid_out <= 1'b0;
        addr_out <= ~a;
    endtask
endmodule
`default_nettype wire

// File: sim/segment_attribute_map_tb.sv
`default_nettype none
module segment_attribute_map_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, cpu_addr_in, pci_addr_in;
    logic pready, pslverr, err, cpu_valid_in, cpu_write_in, cpu_code_in;
    logic pci_valid_in, pci_write_in, pci_claim_out, pci_code;
    logic cpu_to_mem_out, cpu_to_pci_out, l1_cacheable_out, l2_alloc_out;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    host_query_src cpu (.clk_in(ref_clk_in), .valid_out(cpu_valid_in),
        .addr_out(cpu_addr_in), .write_out(cpu_write_in), .code_out(cpu_code_in));
    host_query_src pci (.clk_in(ref_clk_in), .valid_out(pci_valid_in),
        .addr_out(pci_addr_in), .write_out(pci_write_in), .code_out(pci_code));
    segment_attribute_map dut (.ref_clk_in, .rst_in, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_valid_in,
        .cpu_addr_in, .cpu_write_in, .cpu_code_in, .cpu_to_mem_out,
        .cpu_to_pci_out, .l1_cacheable_out, .l2_alloc_out, .pci_valid_in,
        .pci_addr_in, .pci_write_in, .pci_claim_out);
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic print_verdict();
        $display("checks %0d fails %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    function automatic logic [11:0] ra(input int i);
        return 12'(4 * (32'(seg_attr_pkg::ATTR_IDX_0) + i));
    endfunction
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge ref_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        do @(posedge ref_clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // m holds {cache, write, read} enables expected at address a
    task automatic probe(input logic [31:0] a, input logic [2:0] m);
        logic [3:0] e, s;
        for (int k = 0; k < 3; k++) begin
            cpu.ask(a, k == 2, k == 1);
            #1;
            e = {m[k == 2], !m[k == 2], m[2] & (m[1] | k == 1), &m[1:0]};
            s = {cpu_to_mem_out, cpu_to_pci_out, l1_cacheable_out,
                l2_alloc_out};
            check("cpu", 32'(e), 32'(s));
        end
        for (int k = 0; k < 2; k++) begin
            pci.ask(a, k[0], 1'b0);
            #1;
            check("claim", 32'(m[k]), 32'(pci_claim_out));
        end
    endtask
    task automatic t_reset();
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ra(i), 32'h0);
            check("rst", 32'h0, rd);
        end
        apb(1'b1, 12'h004, 32'hFF);
        apb(1'b0, 12'h004, 32'h0);
        check("err", 32'h1, 32'(err));
        check("unm", 32'h0, rd);
        $display("reset done");
    endtask
    task automatic t_modes();
        logic [2:0] ms [6] = '{3'd0, 3'd1, 3'd5, 3'd2, 3'd3, 3'd7};
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ra(1), {28'h0, 1'b1, ms[i]});
            probe(32'hC0000, ms[i]);
            probe(32'hC4000, 3'h0);
        end
        $display("modes done");
    endtask
    task automatic t_decode();
        logic [31:0] a;
        logic [3:0] s;
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, ra(i), 32'h37);
            apb(1'b0, ra(i), 32'h0);
            check("rw", 32'h37, rd);
        end
        probe(32'hF0000, 3'h3);
        probe(32'hFFFFF, 3'h3);
        for (int k = 0; k < 12; k++) begin
            a = 32'hC3FFF + (k << 14);
            probe(a, k[0] ? 3'h3 : 3'h7);
        end
        apb(1'b1, 12'h180, {20'hC0000, 8'hC4, 4'h1});
        pci.ask(32'hC0000, 1'b0, 1'b0);
        #1;
        check("hole", 32'h0, 32'(pci_claim_out));
        pci.ask(32'hC4000, 1'b0, 1'b0);
        #1;
        check("limit", 32'h1, 32'(pci_claim_out));
        cpu.ask(32'h000A0000, 1'b0, 1'b0);
        #1;
        s = {cpu_to_mem_out, cpu_to_pci_out, l1_cacheable_out, l2_alloc_out};
        check("outside", 32'hB, 32'(s));
        $display("decode done");
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_modes();
        t_decode();
        print_verdict();
    end
endmodule
`default_nettype wire
